// >>> verilog/converter_control_pkg.sv
// Purpose: Shared constants and carrier types for the converter control register block.
// Assumes: 100 MHz core clock, 8-bit registers reached through a byte-wide register access port.
// Notes:   Field layout of the control register is carried by sys_ctrl_type, most significant field first.
package converter_control_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REF_SELECT_ADDR     = 8'h00;
    localparam logic [7:0] SYS_CTRL_ONE_ADDR   = 8'h01;
    localparam logic [7:0] REF_SELECT_RESET    = 8'h9e;
    localparam logic [7:0] SYS_CTRL_ONE_RESET  = 8'ha6;
    localparam logic [7:0] READ_ZERO           = 8'h00;
    localparam int         REF_W               = 7;
    localparam int         SLEW_W              = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS          = 10;
    localparam int REF_STEP_UV            = 4000;
    localparam int SLEW_CODE3_UV_PER_US   = 10000;
    localparam int SLEW_CODE7_UV_PER_NS_X1000 = 625;
    localparam int SLEW_CODE_REF          = 3;
    localparam int STEP_NS_CODE3          = (REF_STEP_UV * 1000) / SLEW_CODE3_UV_PER_US;
    localparam int STEP_CYCLES_CODE3      = (STEP_NS_CODE3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CYCLES_CODE0      = STEP_CYCLES_CODE3 >> SLEW_CODE_REF;
    localparam int STEP_CNT_W             = 12;
    localparam int HICCUP_OFF_CYCLES_DEF  = 1000;
    localparam int HICCUP_CNT_W           = 16;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              converter_on;
        logic              scaling_go;
        logic [SLEW_W-1:0] slew_select;
        logic              overvoltage_recovery_select;
        logic              overcurrent_response_select;
        logic              light_load_pwm;
    } sys_ctrl_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_access_type;

    typedef struct packed {
        logic over_voltage;
        logic over_current;
        logic under_voltage;
        logic supply_good;
    } fault_pins_type;

endpackage

// >>> verilog/ref_slew_ramp.sv
// Purpose: Linear ramp of the reference code toward its target, one 4 mV code per step period.
// Assumes: Step period doubles with each slew code; code 3 is 10 mV/us, code 7 is 0.625 mV/us.
// Notes:   The ramp chases the target continuously, so a target change mid-ramp simply redirects it.
`timescale 1ns/1ns
`default_nettype none
module ref_slew_ramp (
    input  wire logic                                     clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     clk_en,
    input  wire logic                                     clear,
    input  wire logic [converter_control_pkg::REF_W-1:0]  target,
    input  wire logic [converter_control_pkg::SLEW_W-1:0] slew_code,
    output logic      [converter_control_pkg::REF_W-1:0]  current_ff,
    output logic                                          at_target
);

    logic [converter_control_pkg::STEP_CNT_W-1:0] step_cnt_ff;
    logic [converter_control_pkg::STEP_CNT_W-1:0] nxt_step_cnt;
    logic [converter_control_pkg::REF_W-1:0]      nxt_current;
    wire  [converter_control_pkg::STEP_CNT_W-1:0] step_period;
    wire                                          step_due;
    wire                                          going_up;

    // ------------------------------------------------------------------
    // Step timing
    // ------------------------------------------------------------------
    assign step_period = converter_control_pkg::STEP_CNT_W'(converter_control_pkg::STEP_CYCLES_CODE0)
                         << slew_code; // see (R9)
    assign at_target   = (current_ff == target);
    assign going_up    = (target > current_ff);
    assign step_due    = (step_cnt_ff == step_period - 1'b1);

    always_comb begin
        nxt_step_cnt = step_cnt_ff;
        nxt_current  = current_ff;
        if (clear || at_target) begin
            nxt_step_cnt = '0;
            if (clear) begin
                nxt_current = converter_control_pkg::REF_SELECT_RESET[converter_control_pkg::REF_W-1:0];
            end
        end else if (step_due) begin
            nxt_step_cnt = '0;
            nxt_current  = going_up ? current_ff + 1'b1 : current_ff - 1'b1; // see (R8)
        end else begin
            nxt_step_cnt = step_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_ff <= '0;
            current_ff  <= converter_control_pkg::REF_SELECT_RESET[converter_control_pkg::REF_W-1:0];
        end else if (clk_en) begin
            step_cnt_ff <= nxt_step_cnt;
            current_ff  <= nxt_current;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !clk_en);

    a_step_spacing: assert property ( // see (R9)
        ($changed(current_ff) && !$past(clear)) |-> ($past(step_cnt_ff) == $past(step_period) - 1'b1))
        else $error("Reference stepped before its slew period elapsed.");

    a_ramp_linear: assert property ( // see (R8)
        (!clear && !at_target && step_due) |=>
            (clear || current_ff == ($past(going_up) ? $past(current_ff) + 1'b1 : $past(current_ff) - 1'b1)))
        else $error("Reference did not move one code toward the target.");

endmodule
`default_nettype wire

// >>> verilog/converter_control.sv
// Purpose: Control register of a step-down converter with reference scaling, light-load mode and protection policy.
// Assumes: A serial front end delivers decoded byte accesses on the same clock; enable and fault pins are asynchronous.
// Notes:   The enable pin acts as a global reset of the register file and of the serial access path.
//
// Summary of operation
// (R1) With the enable pin high, clearing the on bit stops both switches and setting it again resumes switching.
// (R2) With the enable pin low the converter is off and no register access is taken or answered.
// (R3) The on bit resets to one so the converter runs by default once the enable pin is high.
// (R4) Writes to the reference setting are taken only while the scaling go flag, reset zero, is set.
// (R5) When a commanded reference change has finished slewing, the go flag clears itself.
// (R6) While the go flag is set PWM is forced, and afterwards the light-load mode bit decides again.
// (R7) The host sets the go flag, writes the reference, and polls the flag for zero before the next change.
// (R8) During a change the reference ramps linearly at the rate of the three-bit slew field, reset 100.
// (R9) Slew code 011 gives 10 mV/us and code 111 gives 0.625 mV/us.
// (R10) With the recovery bit at one, its reset value, switching resumes once over-voltage goes away.
// (R11) With the recovery bit at zero, an over-voltage latches the converter off until supply or enable toggles.
// (R12) With the over-current response bit at one, its reset value, over-current with under-voltage starts hiccup.
// (R13) With the over-current response bit at zero, over-current with under-voltage latches the converter off.
// (R14) The light-load mode bit selects automatic PFM/PWM when zero, its reset value, and forced PWM when one.
// (R15) The gated reference value is the low seven bits of register 00.
// (R16) The host updates a register with start, device address, register address byte and one data byte.
// (R17) A protection latch-off holds until the supply drops or the enable pin goes low, either of which clears it.
`timescale 1ns/1ns
`default_nettype none
module converter_control #(
    parameter int HICCUP_OFF_CYCLES = converter_control_pkg::HICCUP_OFF_CYCLES_DEF
) (
    input  wire logic                                    clk,
    input  wire logic                                    rstn,
    input  wire logic                                    clk_en,
    input  wire logic                                    enable_pin,
    input  wire converter_control_pkg::fault_pins_type   fault_pins,
    input  wire converter_control_pkg::reg_access_type   reg_access,
    output logic      [7:0]                              reg_rdata_ff,
    output logic                                         reg_rvalid_ff,
    output logic                                         serial_active_ff,
    output logic                                         high_side_switch_enable_ff,
    output logic                                         low_side_switch_enable_ff,
    output logic                                         forced_pwm_ff,
    output logic                                         hiccup_active_ff,
    output logic                                         latched_off_ff,
    output logic      [converter_control_pkg::REF_W-1:0] reference_code_ff
);

    // ------------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------------
    logic       rst_meta_ff;
    logic       rst_n_sync_ff;
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_sync_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff   <= 1'b0;
            rst_n_sync_ff <= 1'b0;
        end else if (clk_en) begin
            rst_meta_ff   <= 1'b1;
            rst_n_sync_ff <= rst_meta_ff;
        end
    end

    // The first stage feeds only the second; all logic reads pin_sync_ff.
    always_ff @(posedge clk or negedge rst_n_sync_ff) begin
        if (!rst_n_sync_ff) begin
            pin_meta_ff <= 5'h00;
            pin_sync_ff <= 5'h00;
        end else if (clk_en) begin
            pin_meta_ff <= {enable_pin, fault_pins};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    converter_control_pkg::fault_pins_type faults;
    wire enable_sync;
    assign enable_sync = pin_sync_ff[4];
    assign faults      = pin_sync_ff[3:0];

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    converter_control_pkg::sys_ctrl_type ctrl_ff;
    converter_control_pkg::sys_ctrl_type nxt_ctrl;
    logic [7:0] ref_select_ff;
    logic [7:0] nxt_ref_select;
    logic       ramp_pending_ff;
    wire        ramp_at_target;
    wire        ramp_done;
    wire        wr_ctrl;
    wire        wr_ref;
    wire        rd_take;
    wire [7:0]  rd_mux;

    assign wr_ctrl   = reg_access.wr && enable_sync
                       && (reg_access.addr == converter_control_pkg::SYS_CTRL_ONE_ADDR); // see (R2)
    assign wr_ref    = reg_access.wr && enable_sync && ctrl_ff.scaling_go
                       && (reg_access.addr == converter_control_pkg::REF_SELECT_ADDR); // see (R4)
    assign rd_take   = reg_access.rd && enable_sync; // see (R2)
    assign ramp_done = ramp_pending_ff && ramp_at_target;
    assign rd_mux    = (reg_access.addr == converter_control_pkg::REF_SELECT_ADDR)   ? ref_select_ff :
                       (reg_access.addr == converter_control_pkg::SYS_CTRL_ONE_ADDR) ? ctrl_ff :
                       converter_control_pkg::READ_ZERO;

    // Only the low seven bits are writable; the reserved top bit keeps its reset value.
    assign nxt_ref_select = wr_ref ? {converter_control_pkg::REF_SELECT_RESET[7], reg_access.data[6:0]}
                                   : ref_select_ff; // see (R15)

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ramp_done) begin
            nxt_ctrl.scaling_go = 1'b0; // see (R5)
        end
        // A host write lands after the self-clear, so a new go set in the same cycle wins.
        if (wr_ctrl) begin
            nxt_ctrl = reg_access.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync_ff) begin
        if (!rst_n_sync_ff) begin
            ctrl_ff         <= converter_control_pkg::SYS_CTRL_ONE_RESET;
            ref_select_ff   <= converter_control_pkg::REF_SELECT_RESET;
            ramp_pending_ff <= 1'b0;
        end else if (clk_en) begin
            if (!enable_sync) begin
                ctrl_ff         <= converter_control_pkg::SYS_CTRL_ONE_RESET; // see (R3)
                ref_select_ff   <= converter_control_pkg::REF_SELECT_RESET;
                ramp_pending_ff <= 1'b0;
            end else begin
                ctrl_ff         <= nxt_ctrl;
                ref_select_ff   <= nxt_ref_select;
                ramp_pending_ff <= wr_ref || (ramp_pending_ff && !ramp_at_target);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync_ff) begin
        if (!rst_n_sync_ff) begin
            reg_rdata_ff     <= 8'h00;
            reg_rvalid_ff    <= 1'b0;
            serial_active_ff <= 1'b0;
        end else if (clk_en) begin
            reg_rdata_ff     <= rd_take ? rd_mux : 8'h00;
            reg_rvalid_ff    <= rd_take;
            serial_active_ff <= enable_sync; // see (R2)
        end
    end

    // ------------------------------------------------------------------
    // Reference ramp
    // ------------------------------------------------------------------
    ref_slew_ramp u_ramp (
        .clk        (clk),
        .rst_n      (rst_n_sync_ff),
        .clk_en     (clk_en),
        .clear      (!enable_sync),
        .target     (ref_select_ff[converter_control_pkg::REF_W-1:0]),
        .slew_code  (ctrl_ff.slew_select),
        .current_ff (reference_code_ff),
        .at_target  (ramp_at_target)
    );

    // ------------------------------------------------------------------
    // Protection and switching
    // ------------------------------------------------------------------
    logic [converter_control_pkg::HICCUP_CNT_W-1:0] hiccup_cnt_ff;
    wire  running;
    wire  ocp_uvp;
    wire  latch_clear;
    wire  latch_event;
    wire  hiccup_start;
    wire  nxt_switch;
    wire  nxt_forced_pwm;

    assign running      = enable_sync && ctrl_ff.converter_on;
    assign ocp_uvp      = faults.over_current && faults.under_voltage;
    assign latch_clear  = !enable_sync || !faults.supply_good; // see (R17)
    assign latch_event  = running && ((faults.over_voltage && !ctrl_ff.overvoltage_recovery_select) // see (R11)
                                      || (ocp_uvp && !ctrl_ff.overcurrent_response_select)); // see (R13)
    assign hiccup_start = running && ocp_uvp && ctrl_ff.overcurrent_response_select && !hiccup_active_ff; // see (R12)
    // Over-voltage, supply loss or over-current with under-voltage stops switching at once; with recovery selected it resumes when the fault goes away.
    assign nxt_switch   = running && faults.supply_good && !faults.over_voltage && !ocp_uvp // see (R10)
                          && !latched_off_ff && !latch_event && !hiccup_active_ff; // see (R1)
    assign nxt_forced_pwm = ctrl_ff.scaling_go || ctrl_ff.light_load_pwm; // see (R6) see (R14)

    always_ff @(posedge clk or negedge rst_n_sync_ff) begin
        if (!rst_n_sync_ff) begin
            latched_off_ff   <= 1'b0;
            hiccup_active_ff <= 1'b0;
            hiccup_cnt_ff    <= '0;
        end else if (clk_en) begin
            latched_off_ff <= !latch_clear && (latched_off_ff || latch_event); // see (R17)
            if (!enable_sync) begin
                hiccup_active_ff <= 1'b0;
                hiccup_cnt_ff    <= '0;
            end else if (hiccup_start) begin
                hiccup_active_ff <= 1'b1;
                hiccup_cnt_ff    <= converter_control_pkg::HICCUP_CNT_W'(HICCUP_OFF_CYCLES - 1);
            end else if (hiccup_active_ff) begin
                hiccup_cnt_ff    <= hiccup_cnt_ff - 1'b1;
                hiccup_active_ff <= (hiccup_cnt_ff != '0);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync_ff) begin
        if (!rst_n_sync_ff) begin
            high_side_switch_enable_ff <= 1'b0;
            low_side_switch_enable_ff  <= 1'b0;
            forced_pwm_ff              <= 1'b0;
        end else if (clk_en) begin
            high_side_switch_enable_ff <= nxt_switch;
            low_side_switch_enable_ff  <= nxt_switch;
            forced_pwm_ff              <= nxt_forced_pwm;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_sync_ff || !clk_en);

    a_on_bit_stop: assert property ( // see (R1)
        (enable_sync && !ctrl_ff.converter_on) |=> (!high_side_switch_enable_ff && !low_side_switch_enable_ff))
        else $error("Switches ran with the on bit cleared.");

    a_enable_low_off: assert property ( // see (R2)
        !enable_sync |=> (!high_side_switch_enable_ff && !serial_active_ff && !reg_rvalid_ff))
        else $error("Converter or serial path active with enable low.");

    a_enable_reset_ctrl: assert property ( // see (R3)
        !enable_sync |=> (ctrl_ff == converter_control_pkg::SYS_CTRL_ONE_RESET && ctrl_ff.converter_on))
        else $error("Control register not at reset value while enable is low.");

    a_ref_write_gate: assert property ( // see (R4)
        (enable_sync && reg_access.wr && !ctrl_ff.scaling_go
            && reg_access.addr == converter_control_pkg::REF_SELECT_ADDR)
            |=> $stable(ref_select_ff))
        else $error("Reference accepted without the go flag.");

    a_go_self_clear: assert property ( // see (R5)
        (ramp_done && !wr_ctrl && enable_sync) |=> !ctrl_ff.scaling_go)
        else $error("Go flag did not clear after the ramp finished.");

    a_go_forces_pwm: assert property ( // see (R6)
        ctrl_ff.scaling_go |=> forced_pwm_ff)
        else $error("PWM not forced during scaling.");

    a_light_load_mode: assert property ( // see (R14)
        (!ctrl_ff.scaling_go && !ctrl_ff.light_load_pwm) ##1 (!ctrl_ff.scaling_go && !ctrl_ff.light_load_pwm)
            |-> !forced_pwm_ff)
        else $error("PWM forced with automatic light-load mode.");

    a_ovp_retry: assert property ( // see (R10)
        // A latch already held, or one set by over-current in the same cycle, rightly keeps the switches off.
        (running && ctrl_ff.overvoltage_recovery_select && faults.over_voltage
            && !latch_event && !latched_off_ff) |=>
            (!high_side_switch_enable_ff && !latched_off_ff))
        else $error("Over-voltage with recovery selected did not just pause switching.");

    a_ovp_latch: assert property ( // see (R11)
        (running && faults.supply_good && !ctrl_ff.overvoltage_recovery_select && faults.over_voltage)
            |=> latched_off_ff)
        else $error("Over-voltage did not latch off.");

    a_ocp_hiccup: assert property ( // see (R12)
        (hiccup_start && faults.supply_good) |=> (hiccup_active_ff && !high_side_switch_enable_ff))
        else $error("Over-current did not start hiccup.");

    a_ocp_latch: assert property ( // see (R13)
        (running && faults.supply_good && ocp_uvp && !ctrl_ff.overcurrent_response_select) |=> latched_off_ff)
        else $error("Over-current did not latch off.");

    a_latch_release: assert property ( // see (R17)
        latch_clear |=> !latched_off_ff)
        else $error("Latch-off survived a supply or enable drop.");

endmodule
`default_nettype wire

// >>> test/reg_host_model.sv
// Purpose: Host model that drives byte accesses on the register port.
// Assumes: One access at a time, each launched just after a rising edge.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module reg_host_model (
    input  wire logic                                 clk,
    input  wire logic [7:0]                           rdata,
    input  wire logic                                 rvalid,
    output var  converter_control_pkg::reg_access_type acc
);
    initial acc = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) acc <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk) acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk) acc <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h5a};
        @(posedge clk) acc <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'ha5};
        @(posedge clk) begin
            v = rvalid;
            d = rdata;
        end
    endtask

    // Polling is bounded so a flag that never clears ends as not done.
    task automatic scale(input logic [7:0] ctrl, input logic [6:0] tgt, output logic done);
        logic [7:0] d;
        logic       v;
        done = 1'b0;
        wr(converter_control_pkg::SYS_CTRL_ONE_ADDR, ctrl | 8'h40);
        wr(converter_control_pkg::REF_SELECT_ADDR, {1'b0, tgt});
        for (int i = 0; i < 400 && !done; i++) begin
            rd(converter_control_pkg::SYS_CTRL_ONE_ADDR, d, v);
            done = v & ~d[6];
        end
    endtask
endmodule
`default_nettype wire

// >>> test/converter_control_tb.sv
// Purpose: Self-checking bench for the converter control register block.
// Assumes: Hiccup off period shortened to 4 cycles.
// Notes:   Fault waits cover the two-stage pin synchroniser plus the output register.
`timescale 1ns/1ns
`default_nettype none
module converter_control_tb;
    logic                                  clk = 1'b0;
    logic                                  rstn = 1'b0;
    logic                                  enable_pin = 1'b0;
    converter_control_pkg::fault_pins_type faults = 4'b0001;
    converter_control_pkg::reg_access_type acc;
    logic [7:0] rdata, d;
    logic       rvalid, v, serial, hs, ls, pwm, hic, lat, done;
    logic [6:0] ref_code, prev_ref;
    int         compares = 0, miscompares = 0, cyc = 0, age = 0, gap = 0, per;

    always #5 clk = ~clk;

    converter_control #(.HICCUP_OFF_CYCLES(4)) i_dut (.clk(clk), .rstn(rstn), .clk_en(1'b1),
        .enable_pin(enable_pin), .fault_pins(faults), .reg_access(acc), .reg_rdata_ff(rdata),
        .reg_rvalid_ff(rvalid), .serial_active_ff(serial), .high_side_switch_enable_ff(hs),
        .low_side_switch_enable_ff(ls), .forced_pwm_ff(pwm), .hiccup_active_ff(hic),
        .latched_off_ff(lat), .reference_code_ff(ref_code));
    reg_host_model i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .acc(acc));

    // The gap runs from the last reference write on the port to the latest ramp step.
    always @(posedge clk) begin
        age <= (acc.wr && acc.addr == 8'h00) ? 0 : age + 1;
        if (ref_code !== prev_ref) gap <= age;
        prev_ref <= ref_code;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask
    task automatic fault(input logic [3:0] f, input int n);
        @(posedge clk) faults <= f;
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        enable_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(8'h01, 8'ha6);
        rdchk(8'h00, 8'h9e);
        rdchk(8'h05, 8'h00);
        chk({5'h00, pwm, hs, ls}, 8'h03);
        i_host.wr(8'h00, 8'h10);
        rdchk(8'h00, 8'h9e);
        i_host.wr(8'h01, 8'ha7);
        fault(4'b0001, 2);
        chk({7'h00, pwm}, 8'h01);
        i_host.wr(8'h01, 8'h26);
        fault(4'b0001, 2);
        chk({6'h00, hs, ls}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            per = k ? 640 : 40;
            fork
                i_host.scale({2'b10, k ? 3'b111 : 3'b011, 3'b110}, 7'h1f + 7'(k), done);
                fault(4'b0001, 6);
            join_any
            chk({7'h00, pwm}, 8'h01);
            wait fork;
            chk({7'h00, done}, 8'h01);
            chk({1'b0, ref_code}, 8'h1f + 8'(k));
            chk({7'h00, gap >= per - 1 && gap <= per + 2}, 8'h01);
            chk({6'h00, pwm, hs}, 8'h01);
            i_host.wr(8'h00, 8'h05);
            rdchk(8'h00, 8'h9f + 8'(k));
        end
        fault(4'b1001, 6);
        chk({6'h00, hs, ls}, 8'h00);
        fault(4'b0001, 6);
        chk({5'h00, lat, hs, ls}, 8'h03);
        i_host.wr(8'h01, 8'ha2);
        fault(4'b1001, 6);
        fault(4'b0001, 6);
        chk({5'h00, lat, hs, ls}, 8'h04);
        fault(4'b0000, 6);
        fault(4'b0001, 6);
        chk({5'h00, lat, hs, ls}, 8'h03);
        i_host.wr(8'h01, 8'ha6);
        fault(4'b0111, 5);
        chk({6'h00, hic, lat}, 8'h02);
        fault(4'b0001, 12);
        chk({5'h00, hic, hs, ls}, 8'h03);
        i_host.wr(8'h01, 8'ha4);
        fault(4'b0111, 6);
        fault(4'b0001, 6);
        chk({5'h00, lat, hs, ls}, 8'h04);
        enable_pin <= 1'b0;
        fault(4'b0001, 6);
        chk({4'h0, serial, lat, hs, ls}, 8'h00);
        i_host.rd(8'h01, d, v);
        chk({7'h00, v}, 8'h00);
        enable_pin <= 1'b1;
        fault(4'b0001, 8);
        chk({6'h00, hs, ls}, 8'h03);
        rdchk(8'h01, 8'ha6);
        report_and_stop();
    end
endmodule
`default_nettype wire
